// ===== include/ascr_cfg.svh
/*
 * Constants of the acquisition scan control register bank: offsets,
 * field positions, reset values and timeout counts.
 * Assumes a 50 MHz clock and an AHB-Lite register bus with 32-bit data.
 */
// How it works
// - Init request set: accumulators reload with the first measurement taken.
// - Init request clear: accumulators keep contents and fold new measurements in.
// - Six aux enable bits include their input when 1; reset value is 0.
// - Aux pin set for general I/O: enable ignored, still reads back.
// - Two-wire master selected: aux 0 and 1 enables ignored, still read back.
// - Calibration request runs ADC calibration; scan measurements skipped meanwhile.
// - Balance-switch and sense-wire diagnostic scans override other settings while running.
// - Complete flag low while an acquisition runs, high once it finishes.
// - While complete flag is high, new start requests are ignored.
// - Writing 0 clears the complete flag; writing 1 does nothing.
// - Timeout flag sets when acquisition overruns; limit depends on oversampling.
// - Writing 0 clears the timeout flag; writing 1 does nothing.
// - Watchdog disable bit inhibits the acquisition timeout watchdog.
// - Result ready flag sets when results move to data registers; write 0 clears.
// - Filter update enable: conversions fold into accumulators at sequence end.
`ifndef ASCR_CFG_SVH
`define ASCR_CFG_SVH

// ****************************************************************
// Register index and byte addresses
// ****************************************************************
`define ASCR_IDX_AUX_MEASURE_ENABLE 8'h65
`define ASCR_IDX_CTRL 8'h66
`define ASCR_IDX_MODE 8'h67
`define ASCR_ADDR_W 10
`define ASCR_ADDR_AUX_MEASURE_ENABLE 10'h194
`define ASCR_ADDR_CTRL 10'h198
`define ASCR_ADDR_MODE 10'h19c

// ****************************************************************
// Field positions
// ****************************************************************
`define ASCR_B_IIRINIT 15
`define ASCR_B_DONE 15
`define ASCR_B_TMO 14
`define ASCR_B_RDY 13
`define ASCR_B_AMEND 10
`define ASCR_B_START 0
`define ASCR_B_CAL 0
`define ASCR_B_BALDIAG 1
`define ASCR_B_WDDIS 2
`define ASCR_B_TWI 3
`define ASCR_F_AUX 5:0
`define ASCR_F_CFG 9:1
// Oversample count inside the stored config, which starts one bit above start
`define ASCR_F_OVS 4:2
`define ASCR_F_GPIO 9:4

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define ASCR_RST_AUX 6'h00
`define ASCR_RST_CFG 9'h000
`define ASCR_RST_MODE 10'h000
`define ASCR_AUX_TWI_MASK 6'h03
`define ASCR_AUX_W 6

// ****************************************************************
// Timeout: base time at oversample 0, doubled per oversample step, in microseconds
// ****************************************************************
`define ASCR_CLK_MHZ 50
`define ASCR_TMO_BASE_US 500
`define ASCR_TMO_BASE_CYC (24'(`ASCR_TMO_BASE_US * `ASCR_CLK_MHZ))
`define ASCR_TMO_W 24

`endif

// ===== include/ascr_pkg.sv
/*
 * Types of the acquisition scan control register bank.
 * Assumes the aux and config widths of ascr_cfg.svh, written here as literals.
 */
package ascr_pkg;

  // Sequencer launch request towards the measurement engines
  typedef struct packed {
    logic start;
    logic [5:0] auxEffective;
    logic iirInit;
    logic filterUpdate;
    logic calibrate;
    logic balDiag;
    logic [8:0] acqConfig;
  } ascr_launch_s;

  // Sequencer state
  typedef enum logic [1:0] {
    ASCR_IDLE = 2'b00,
    ASCR_BUSY = 2'b01,
    ASCR_CAL = 2'b10
  } ascr_state_e;

endpackage

// ===== verilog/ascr_aux_gate.sv
/*
 * Effective auxiliary measurement enables: stored enable masked by pin
 * mode and two-wire master selection.
 * Assumes stored values stay readable elsewhere.
 */
`timescale 1ns/1ns
`include "ascr_cfg.svh"
module ascr_aux_gate (
  // Stored setting and pin modes
  input wire logic [`ASCR_AUX_W-1:0] auxMeasureEnable,
  input wire logic [`ASCR_AUX_W-1:0] auxPinIoSelect,
  input wire logic twowireMasterSelect,
  // Gated result
  output logic [`ASCR_AUX_W-1:0] auxEffective
);
  logic [`ASCR_AUX_W-1:0] twiMask;

  // Two-wire master owns aux 0 and 1
  assign twiMask = twowireMasterSelect ? `ASCR_AUX_TWI_MASK : '0;
  // Pins in I/O mode are never measured
  assign auxEffective = auxMeasureEnable & ~auxPinIoSelect & ~twiMask;
endmodule

// ===== verilog/ascr_watchdog.sv
/*
 * Acquisition watchdog: counts while an acquisition runs and flags
 * an overrun once the oversample-scaled limit is reached.
 * Assumes a one-cycle clear at each launch.
 */
`timescale 1ns/1ns
`include "ascr_cfg.svh"
module ascr_watchdog #(
  parameter logic [`ASCR_TMO_W-1:0] BASE_CYC = `ASCR_TMO_BASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic inhibit,
  input wire logic [2:0] oversample,
  // Overrun pulse
  output logic expired
);
  logic [`ASCR_TMO_W-1:0] count_r;
  logic [`ASCR_TMO_W-1:0] limit;

  // Limit doubles with each oversample step
  assign limit = BASE_CYC << oversample;

  // Cycle counter, frozen when inhibited
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (restart) begin
      count_r <= '0;
    end else if (run && !inhibit && count_r != limit) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Single pulse on reaching the limit
  assign expired = run && !inhibit && (count_r == limit - 1'b1) && !restart;
endmodule

// ===== verilog/ascr_regs.sv
/*
 * Acquisition scan control register bank: aux measurement enables,
 * IIR init request, completion/timeout/result-ready flags, and launch
 * control towards the sequencer, reached over AHB-Lite.
 * Assumes a sequencer that pulses seqDone, calDone and resultMoved.
 */
`timescale 1ns/1ns
`include "ascr_cfg.svh"
module ascr_regs #(
  parameter logic [`ASCR_TMO_W-1:0] TMO_BASE_CYC = `ASCR_TMO_BASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Sequencer status
  input wire logic seqDone,
  input wire logic calDone,
  input wire logic resultMoved,
  // Launch to sequencer
  output ascr_pkg::ascr_launch_s launch
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [`ASCR_AUX_W-1:0] aux_measure_enable_r;
  logic iirInit_r;
  logic [8:0] cfg_r;
  logic filterUpdate_r;
  logic [9:0] mode_r;
  logic done_r;
  logic tmo_r;
  logic rdy_r;
  ascr_pkg::ascr_state_e state_r;
  ascr_pkg::ascr_launch_s launch_r;
  logic [31:0] hrdata_r;
  logic wrPend_r;
  logic [`ASCR_ADDR_W-1:0] wrAddr_r;

  logic [`ASCR_AUX_W-1:0] auxEffective;
  logic addrPhase;
  logic wrAux;
  logic wrCtrl;
  logic wrMode;
  logic startReq;
  logic calReq;
  logic tmoPulse;
  logic seqEnd;
  logic launchNow;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Every access completes in zero wait states
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Capture write address for the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= haddr[`ASCR_ADDR_W-1:0];
    end
  end

  assign wrAux = wrPend_r && wrAddr_r == `ASCR_ADDR_AUX_MEASURE_ENABLE;
  assign wrCtrl = wrPend_r && wrAddr_r == `ASCR_ADDR_CTRL;
  assign wrMode = wrPend_r && wrAddr_r == `ASCR_ADDR_MODE;

  // Read data registered at the address phase; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= '0;
    end else if (addrPhase && !hwrite) begin
      unique case (haddr[`ASCR_ADDR_W-1:0])
        `ASCR_ADDR_AUX_MEASURE_ENABLE: hrdata_r <= {16'h0000, iirInit_r, 9'h000, aux_measure_enable_r};
        `ASCR_ADDR_CTRL: hrdata_r <= {16'h0000, done_r, tmo_r, rdy_r, 2'b00,
                                      filterUpdate_r, cfg_r, 1'b0};
        `ASCR_ADDR_MODE: hrdata_r <= {22'h000000, mode_r};
        default: hrdata_r <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Software-written settings
  // ****************************************************************
  // Aux enables and IIR init request; hold their value whatever the pin mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_measure_enable_r <= `ASCR_RST_AUX;
      iirInit_r <= 1'b0;
    end else if (wrAux) begin
      aux_measure_enable_r <= hwdata[`ASCR_F_AUX];
      iirInit_r <= hwdata[`ASCR_B_IIRINIT];
    end
  end

  // Plain read/write fields of the control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `ASCR_RST_CFG;
      filterUpdate_r <= 1'b0;
    end else if (wrCtrl) begin
      cfg_r <= hwdata[`ASCR_F_CFG];
      filterUpdate_r <= hwdata[`ASCR_B_AMEND];
    end
  end

  // Mode register: calibrate, diag, watchdog disable, two-wire, pin I/O
  // Calibrate bit self-clears once accepted so it acts as a command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `ASCR_RST_MODE;
    end else if (wrMode) begin
      mode_r <= hwdata[9:0];
    end else if (calReq) begin
      mode_r[`ASCR_B_CAL] <= 1'b0;
    end
  end

  // ****************************************************************
  // Gating of aux enables
  // ****************************************************************
  ascr_aux_gate u_gate (
    .auxMeasureEnable(aux_measure_enable_r),
    .auxPinIoSelect(mode_r[`ASCR_F_GPIO]),
    .twowireMasterSelect(mode_r[`ASCR_B_TWI]),
    .auxEffective(auxEffective)
  );

  // ****************************************************************
  // Sequencer control
  // ****************************************************************
  // Start ignored while the complete flag is high
  assign startReq = wrCtrl && hwdata[`ASCR_B_START] && !done_r;
  assign calReq = mode_r[`ASCR_B_CAL] && state_r == ascr_pkg::ASCR_IDLE;
  assign launchNow = startReq && state_r == ascr_pkg::ASCR_IDLE && !calReq;
  assign seqEnd = (state_r == ascr_pkg::ASCR_BUSY) && (seqDone || tmoPulse);

  // Calibration wins over scans; start requests during it are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ascr_pkg::ASCR_IDLE;
    end else begin
      unique case (state_r)
        ascr_pkg::ASCR_IDLE: begin
          if (calReq) begin
            state_r <= ascr_pkg::ASCR_CAL;
          end else if (launchNow) begin
            state_r <= ascr_pkg::ASCR_BUSY;
          end
        end
        ascr_pkg::ASCR_BUSY: begin
          if (seqDone || tmoPulse) begin
            state_r <= ascr_pkg::ASCR_IDLE;
          end
        end
        ascr_pkg::ASCR_CAL: begin
          if (calDone) begin
            state_r <= ascr_pkg::ASCR_IDLE;
          end
        end
        default: state_r <= ascr_pkg::ASCR_IDLE;
      endcase
    end
  end

  // Launch bundle: one-cycle start with settings frozen at launch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      launch_r <= '0;
    end else begin
      launch_r.start <= launchNow;
      launch_r.calibrate <= calReq || (state_r == ascr_pkg::ASCR_CAL && !calDone);
      if (launchNow) begin
        launch_r.auxEffective <= auxEffective;
        launch_r.iirInit <= iirInit_r;
        // Start write carries its own settings, so take them from the bus
        launch_r.filterUpdate <= hwdata[`ASCR_B_AMEND];
        launch_r.balDiag <= mode_r[`ASCR_B_BALDIAG];
        launch_r.acqConfig <= hwdata[`ASCR_F_CFG];
      end
    end
  end
  assign launch = launch_r;

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  ascr_watchdog #(
    .BASE_CYC(TMO_BASE_CYC)
  ) u_wd (
    .clk(clk),
    .rst_n(rst_n),
    .run(state_r == ascr_pkg::ASCR_BUSY),
    .restart(launchNow),
    .inhibit(mode_r[`ASCR_B_WDDIS]),
    .oversample(cfg_r[`ASCR_F_OVS]),
    .expired(tmoPulse)
  );

  // ****************************************************************
  // Status flags; hardware set wins over a clearing write
  // ****************************************************************
  // Complete flag: set at sequence end, cleared by a control write with bit 15 at 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else if (seqEnd) begin
      done_r <= 1'b1;
    end else if (wrCtrl && !hwdata[`ASCR_B_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // Timeout flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_r <= 1'b0;
    end else if (tmoPulse) begin
      tmo_r <= 1'b1;
    end else if (wrCtrl && !hwdata[`ASCR_B_TMO]) begin
      tmo_r <= 1'b0;
    end
  end

  // Result ready flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_r <= 1'b0;
    end else if (resultMoved) begin
      rdy_r <= 1'b1;
    end else if (wrCtrl && !hwdata[`ASCR_B_RDY]) begin
      rdy_r <= 1'b0;
    end
  end
endmodule

// ===== tb/ascr_regs_asserts.sv
/* Port checker of the acquisition control register bank.
   Assumes the byte addresses of ascr_cfg.svh and upper haddr bits at zero. */
`timescale 1ns/1ns
`include "ascr_cfg.svh"
module ascr_regs_asserts #(
  parameter logic [`ASCR_TMO_W-1:0] TMO_BASE_CYC = `ASCR_TMO_BASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Sequencer
  input wire logic seqDone,
  input wire logic calDone,
  input wire logic resultMoved,
  input wire ascr_pkg::ascr_launch_s launch
);
  // ****************************************************************
  // Data-phase trackers
  // ****************************************************************
  wire logic tk = hsel && hready && htrans[1];
  wire logic isCtrl = haddr[9:0] == `ASCR_ADDR_CTRL;
  wire logic isAux = haddr[9:0] == `ASCR_ADDR_AUX_MEASURE_ENABLE;
  logic [3:0] ph_r;
  logic iirSet_r;
  // One flop behind each address phase so data checks line up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ph_r <= 4'h0;
    else
      ph_r <= {tk && hwrite && isCtrl, tk && !hwrite && isCtrl, tk && hwrite && isAux,
               tk && !hwrite && isAux};
  end
  // Shadow of the init request, taken from completed aux writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      iirSet_r <= 1'b0;
    else if (ph_r[1])
      iirSet_r <= hwdata[15];
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  start_pulse_a: assert property (launch.start |=> !launch.start [*3])
    else $error("launch repeated too soon");
  start_cause_a: assert property (launch.start |-> $past(ph_r[3] && hwdata[0]))
    else $error("launch without a start write");
  ctrl_zero_a: assert property (
    ph_r[2] |-> hrdata[0] == 1'b0 && hrdata[12:11] == 2'b00 && hrdata[31:16] == 16'h0000)
    else $error("control read shows unused bits");
  aux_zero_a: assert property (
    ph_r[0] |-> hrdata[14:6] == 9'h000 && hrdata[31:16] == 16'h0000)
    else $error("aux read shows unused bits");
  cal_excl_a: assert property (launch.calibrate |-> !launch.start)
    else $error("launch during calibration");
  fields_held_a: assert property (
    !launch.start |-> $stable(launch.auxEffective) && $stable(launch.acqConfig))
    else $error("launch fields moved without launch");
  iir_follow_a: assert property (launch.start |-> launch.iirInit == iirSet_r)
    else $error("init request not passed on");
endmodule
bind ascr_regs ascr_regs_asserts #(.TMO_BASE_CYC(TMO_BASE_CYC)) ascr_regs_asserts_i (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .seqDone(seqDone), .calDone(calDone), .resultMoved(resultMoved),
  .launch(launch));

// ===== tb/tb_ascr_regs.sv
/* Self-checking bench of the acquisition control register bank.
   Assumes a zero-wait slave; sequencer pulses are driven here. */
`timescale 1ns/1ns
`include "ascr_cfg.svh"
module tb_ascr_regs;
  localparam logic [23:0] BASE = 24'h000014;
  localparam logic [9:0] A_AUX = `ASCR_ADDR_AUX_MEASURE_ENABLE;
  localparam logic [9:0] A_CTRL = `ASCR_ADDR_CTRL;
  localparam logic [9:0] A_MODE = `ASCR_ADDR_MODE;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, seed, a, m, c;
  logic [1:0] htrans;
  logic [2:0] hsize, evt;
  logic rdPh = 1'b0;
  ascr_pkg::ascr_launch_s launch;
  ascr_pkg::ascr_launch_s launchQ[$];
  logic [31:0] expQ[$];
  int mismatches, cmpCount, cyc;
  ascr_regs #(.TMO_BASE_CYC(BASE)) ascr_regs_i (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .seqDone(evt[0]), .calDone(evt[1]), .resultMoved(evt[2]), .launch(launch));
  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic fail(input string s);
    mismatches++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task automatic cmpRead(input logic [31:0] e);
    cmpCount++;
    if (hrdata !== e) fail("read data differs");
  endtask
  task automatic cmpLaunch(input ascr_pkg::ascr_launch_s e);
    cmpCount++;
    if (launch !== e) fail("launch fields differ");
  endtask
  task automatic cmpBit(input logic g, input logic e);
    cmpCount++;
    if (g !== e) fail("level differs");
  endtask
  // Single transfer; for a read d is the expected word
  task automatic bus(input logic wr, input logic [9:0] ad, input logic [31:0] d);
    if (!wr) expQ.push_back(d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h0, ad};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  // One-cycle sequencer pulse: bit0 done, bit1 calibrated, bit2 results moved
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    evt <= p;
    @(posedge clk);
    evt <= 3'b000;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************************************
  // Watchers: read data in its data phase, launches as they pulse
  // ****************************************************************
  always @(posedge clk) rdPh <= hsel && htrans[1] && !hwrite && hreadyout;
  always @(negedge clk) begin
    if (rdPh) begin
      if (expQ.size() == 0) fail("read without note");
      else cmpRead(expQ.pop_front());
    end
    if (launch.start === 1'b1) begin
      if (launchQ.size() == 0) fail("launch not expected");
      else cmpLaunch(launchQ.pop_front());
    end
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_n, hsel, hwrite, haddr, hwdata, htrans, evt} = '0;
    hsize = 3'b010;
    seed = 32'hf5d89a39;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, A_AUX, 32'h0);
    bus(1'b0, A_CTRL, 32'h0);
    bus(1'b0, A_MODE, 32'h0);
    bus(1'b1, 10'h1a0, 32'hffffffff);
    bus(1'b0, 10'h1a0, 32'h0);
    $display("reset and unmapped test ended");
    // Random enables, pin modes and configs through full launches
    for (int i = 0; i < 8; i++) begin
      a = rnd() & 32'h803f;
      m = rnd() & 32'h3fe;
      c = rnd() & 32'h7fe;
      bus(1'b1, A_AUX, a);
      bus(1'b1, A_MODE, m);
      bus(1'b0, A_AUX, a);
      launchQ.push_back('{1'b1, a[5:0] & ~m[9:4] & ~(m[3] ? 6'h03 : 6'h00),
                          a[15], c[10], 1'b0, m[1], c[9:1]});
      bus(1'b1, A_CTRL, c | 32'h1);
      bus(1'b0, A_CTRL, c);
      pulse(3'b001);
      bus(1'b1, A_CTRL, c | 32'hc001);
      bus(1'b0, A_CTRL, c | 32'h8000);
      bus(1'b1, A_CTRL, c);
      bus(1'b0, A_CTRL, c);
    end
    $display("enable gating test ended");
    pulse(3'b100);
    bus(1'b0, A_CTRL, c | 32'h2000);
    bus(1'b1, A_CTRL, 32'h2000);
    bus(1'b0, A_CTRL, 32'h2000);
    bus(1'b1, A_CTRL, 32'h0);
    $display("result ready test ended");
    // Oversample 1 doubles the watchdog limit to 40 cycles
    bus(1'b1, A_AUX, 32'h803f);
    bus(1'b1, A_MODE, 32'h0);
    launchQ.push_back('{1'b1, 6'h3f, 1'b1, 1'b0, 1'b0, 1'b0, 9'h004});
    bus(1'b1, A_CTRL, 32'h9);
    repeat (25) @(posedge clk);
    bus(1'b0, A_CTRL, 32'h8);
    repeat (40) @(posedge clk);
    bus(1'b0, A_CTRL, 32'hc008);
    bus(1'b1, A_CTRL, 32'h4008);
    bus(1'b0, A_CTRL, 32'h4008);
    bus(1'b1, A_CTRL, 32'h0);
    bus(1'b1, A_MODE, 32'h4);
    bus(1'b1, A_AUX, 32'h803f);
    launchQ.push_back('{1'b1, 6'h3f, 1'b1, 1'b0, 1'b0, 1'b0, 9'h000});
    bus(1'b1, A_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    bus(1'b0, A_CTRL, 32'h0);
    pulse(3'b001);
    bus(1'b0, A_CTRL, 32'h8000);
    bus(1'b1, A_CTRL, 32'h0);
    $display("watchdog test ended");
    bus(1'b1, A_MODE, 32'h1);
    repeat (3) @(negedge clk);
    cmpBit(launch.calibrate, 1'b1);
    pulse(3'b010);
    repeat (3) @(negedge clk);
    cmpBit(launch.calibrate, 1'b0);
    bus(1'b0, A_MODE, 32'h0);
    $display("calibration test ended");
    repeat (3) @(posedge clk);
    cmpBit(expQ.size() + launchQ.size() == 0, 1'b1);
    give_verdict();
  end
endmodule
